// ==== src/fscr_regs.svh ====
// Offsets, field positions, reset values and timing counts of the status register bank.
`ifndef FSCR_REGS_SVH
`define FSCR_REGS_SVH

// ****************************************************************
// Status word selectors
// ****************************************************************
`define FSCR_SEL_ONE        2'h0
`define FSCR_SEL_TWO        2'h1
`define FSCR_SEL_THREE      2'h2

// ****************************************************************
// Field positions within each 8-bit status word
// ****************************************************************
`define FSCR_W1_BUSY        0
`define FSCR_W1_WEL         1
`define FSCR_W1_RANGE_LO    2
`define FSCR_W1_TB          5
`define FSCR_W1_SEC         6
`define FSCR_W1_GUARD       7
`define FSCR_W2_LOCKDOWN    0
`define FSCR_W2_QE          1
`define FSCR_W2_OTP_LO      3
`define FSCR_W2_INVERT      6
`define FSCR_W2_SUS         7
`define FSCR_W3_WPS         2
`define FSCR_W3_DRV_LO      5
`define FSCR_W3_ROLE        7

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define FSCR_RANGE_RST      3'h0
`define FSCR_OTP_RST        3'h0
`define FSCR_DRV_RST        2'h3
`define FSCR_SR_WRITE_CYC   8
`define FSCR_BLOCK_LOCKS    62
`define FSCR_OP_SUSPEND     8'h75
`define FSCR_OP_RESUME      8'h7A
`define FSCR_OP_ENTER_QUAD  8'h38

`endif

// ==== src/fscr_pkg.sv ====
// Types shared by the status register bank and its surroundings.
package fscr_pkg;

  // ****************************************************************
  // Decoded instruction kinds
  // ****************************************************************
  typedef enum logic [3:0] {
    FSCR_READ_SR,
    FSCR_WRITE_SR,
    FSCR_WRITE_ENABLE,
    FSCR_WRITE_DISABLE,
    FSCR_PROGRAM,
    FSCR_ERASE,
    FSCR_OTP_OP,
    FSCR_SUSPEND,
    FSCR_RESUME,
    FSCR_ENTER_QUAD,
    FSCR_EXIT_QUAD,
    FSCR_SOFT_RESET,
    FSCR_BLOCK_LOCK,
    FSCR_BLOCK_UNLOCK
  } fscr_kind_t;

  typedef struct packed {
    logic       valid;
    fscr_kind_t kind;
    logic [1:0] sel;
    logic [7:0] data;
    logic [5:0] index;
  } fscr_cmd_t;

  typedef struct packed {
    logic       busy;
    logic       write_enable_latch;
    logic       paused;
    logic       quad_mode;
    logic [2:0] range;
    logic       from_bottom;
    logic       sectors;
    logic       invert;
    logic       area_scheme;
    logic       lock_scheme;
    logic [2:0] otp_locks;
    logic [6:0] drive_pct;
    logic       guard_pin_en;
    logic       pause_en;
    logic       reset_en;
    logic       lanes23_data;
  } fscr_cfg_t;

endpackage : fscr_pkg

// ==== src/fscr_top.sv ====
// Status and configuration register bank of a serial flash device.
//
// Overview of operation
// RULE_01: Busy flag reads 1 during program, erase, status write or security-area operations.
// RULE_02: While busy, only status reads and suspend instructions are accepted.
// RULE_03: Write enable instruction sets the write enable latch.
// RULE_04: Latch clears at power-up, write disable, program, erase, status or security writes.
// RULE_05: Three range bits are writable by status write, default zero, nothing protected.
// RULE_06: Direction bit zero protects from top, one from bottom.
// RULE_07: Granularity bit one selects 4KB sectors, zero selects 64KB blocks.
// RULE_08: Invert bit swaps protected and unprotected regions, default zero.
// RULE_09: Lockdown and guard mode both zero: status writes need only the latch.
// RULE_10: Guard mode one refuses status writes while the guard pin is low.
// RULE_11: Lockdown one refuses all status writes until the next power cycle.
// RULE_12: Guard pin gates status writes only outside four-lane operation.
// RULE_13: Suspend sets the paused flag; resume or power cycle clears it.
// RULE_14: Three one-time area locks, settable individually, never clearable; reset clears them to zero.
// RULE_15: Four-lane enable turns guard and pause pins into data lanes.
// RULE_16: Entering four-lane command mode is ignored unless four-lane enable is set.
// RULE_17: In four-lane command mode a status write cannot clear four-lane enable.
// RULE_18: Scheme select zero uses range fields, one uses individual block locks.
// RULE_19: All individual block locks become 1 at power-on and every reset.
// RULE_20: Drive level decodes 00,01,10,11 to 100,75,50,25 percent, default 11.
// RULE_21: Shared pin is pause when role is zero, reset when one, lanes off.
// RULE_22: Reserved status bits written as zero have no effect.
`timescale 1ns/1ps
`include "fscr_regs.svh"

module fscr_top
  import fscr_pkg::*;
#(
  parameter int SR_WRITE_CYC = `FSCR_SR_WRITE_CYC,
  parameter int BLOCK_LOCKS  = `FSCR_BLOCK_LOCKS
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  input  wire fscr_cmd_t              i_cmd,
  input  wire logic                   i_op_done,
  input  wire logic                   i_write_guard_pin,
  output logic                        o_rd_valid,
  output logic [7:0]                  o_rd_data,
  output logic                        o_cmd_taken,
  output fscr_cfg_t                   o_cfg,
  output logic [BLOCK_LOCKS-1:0]      o_block_locks
);

  // ****************************************************************
  // Register fields
  // ****************************************************************
  logic       busy, write_enable_latch, paused, quad_mode, array_op, pend_wr;
  logic       tb, sec, guard_mode, invert, lockdown, qe, guard_scheme_select, pin_role;
  logic       guard_meta, guard_sync;
  logic [1:0] drv, pend_sel;
  logic [2:0] range, otp_locks;
  logic [7:0] pend_data, wr_cnt;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [6:0] drive_pct(input logic [1:0] lvl);
    logic [6:0] pct;
    pct = 7'h19;
    // RULE_20 drive level decode
    unique case (lvl)
      2'h0: pct = 7'h64;
      2'h1: pct = 7'h4B;
      2'h2: pct = 7'h32;
      2'h3: pct = 7'h19;
    endcase
    return pct;
  endfunction : drive_pct

  function automatic logic [7:0] status_word(input logic [1:0] sel);
    logic [7:0] w;
    w = 8'h00;
    // RULE_22 reserved bits read zero
    unique case (sel)
      `FSCR_SEL_ONE: begin
        w[`FSCR_W1_BUSY]                     = busy;
        w[`FSCR_W1_WEL]                      = write_enable_latch;
        w[`FSCR_W1_RANGE_LO+2:`FSCR_W1_RANGE_LO] = range;
        w[`FSCR_W1_TB]                       = tb;
        w[`FSCR_W1_SEC]                      = sec;
        w[`FSCR_W1_GUARD]                    = guard_mode;
      end
      `FSCR_SEL_TWO: begin
        w[`FSCR_W2_LOCKDOWN]                 = lockdown;
        w[`FSCR_W2_QE]                       = qe;
        w[`FSCR_W2_OTP_LO+2:`FSCR_W2_OTP_LO] = otp_locks;
        w[`FSCR_W2_INVERT]                   = invert;
        w[`FSCR_W2_SUS]                      = paused;
      end
      `FSCR_SEL_THREE: begin
        w[`FSCR_W3_WPS]                      = guard_scheme_select;
        w[`FSCR_W3_DRV_LO+1:`FSCR_W3_DRV_LO] = drv;
        w[`FSCR_W3_ROLE]                     = pin_role;
      end
      default: w = 8'h00;
    endcase
    return w;
  endfunction : status_word

  // ****************************************************************
  // Acceptance of instructions and guard pin synchroniser
  // ****************************************************************
  logic cmd_ok, pin_gates, sr_wr_ok, is_kind_wr;

  always_comb begin
    // RULE_02 busy filter
    cmd_ok = i_cmd.valid &&
             (!busy || i_cmd.kind == FSCR_READ_SR || i_cmd.kind == FSCR_SUSPEND);
    // RULE_12 pin gates standard and dual only
    pin_gates = !qe && !quad_mode;
    // RULE_09 RULE_10 RULE_11 status write guard
    sr_wr_ok = write_enable_latch && !lockdown && !(guard_mode && pin_gates && !guard_sync) &&
               (i_cmd.sel != 2'h3);
    is_kind_wr = cmd_ok && i_cmd.kind == FSCR_WRITE_SR;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      guard_meta <= 1'b1;
      guard_sync <= 1'b1;
    end else begin
      guard_meta <= i_write_guard_pin;
      guard_sync <= guard_meta;
    end
  end

  // ****************************************************************
  // Busy, suspend, status write timing and write enable latch
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      busy      <= 1'b0;
      paused    <= 1'b0;
      array_op  <= 1'b0;
      pend_wr   <= 1'b0;
      pend_sel  <= 2'h0;
      pend_data <= 8'h00;
      wr_cnt    <= 8'h00;
    end else if (cmd_ok && i_cmd.kind == FSCR_SOFT_RESET) begin
      busy     <= 1'b0;
      paused   <= 1'b0;
      array_op <= 1'b0;
      pend_wr  <= 1'b0;
    end else begin
      pend_wr <= 1'b0;
      if (busy && (!array_op || paused)) begin
        // RULE_01 status write completes after its count
        if (wr_cnt == 8'(SR_WRITE_CYC - 1)) begin
          busy    <= 1'b0;
          pend_wr <= 1'b1;
        end else begin
          wr_cnt <= wr_cnt + 8'h01;
        end
      end else if (busy && i_op_done) begin
        busy     <= 1'b0;
        array_op <= 1'b0;
      end
      if (cmd_ok) begin
        unique case (i_cmd.kind)
          FSCR_PROGRAM, FSCR_ERASE, FSCR_OTP_OP: begin
            // RULE_01 busy during array operations
            if (write_enable_latch && !paused) begin
              busy     <= 1'b1;
              array_op <= 1'b1;
            end
          end
          FSCR_WRITE_SR: begin
            if (sr_wr_ok) begin
              busy      <= 1'b1;
              wr_cnt    <= 8'h00;
              pend_sel  <= i_cmd.sel;
              pend_data <= i_cmd.data;
            end
          end
          FSCR_SUSPEND: begin
            // RULE_13 suspend pauses an array operation
            if (busy && array_op) begin
              busy   <= 1'b0;
              paused <= 1'b1;
            end
          end
          FSCR_RESUME: begin
            // RULE_13 resume clears paused flag
            if (paused) begin
              paused <= 1'b0;
              busy   <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      // RULE_04 cleared at power-up
      write_enable_latch <= 1'b0;
    end else if (cmd_ok) begin
      unique case (i_cmd.kind)
        // RULE_03 write enable sets latch
        FSCR_WRITE_ENABLE: write_enable_latch <= 1'b1;
        // RULE_04 cleared by disable and writes
        FSCR_WRITE_DISABLE, FSCR_SOFT_RESET: write_enable_latch <= 1'b0;
        FSCR_PROGRAM, FSCR_ERASE, FSCR_OTP_OP: write_enable_latch <= write_enable_latch & paused;
        FSCR_WRITE_SR: write_enable_latch <= write_enable_latch & !sr_wr_ok;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Configuration fields, applied when a status write completes
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      // RULE_05 RULE_06 RULE_07 RULE_08 factory defaults
      range      <= `FSCR_RANGE_RST;
      tb         <= 1'b0;
      sec        <= 1'b0;
      guard_mode <= 1'b0;
      invert     <= 1'b0;
      // RULE_11 power cycle releases lockdown
      lockdown   <= 1'b0;
      otp_locks  <= `FSCR_OTP_RST;
      qe         <= 1'b0;
      guard_scheme_select        <= 1'b0;
      drv        <= `FSCR_DRV_RST;
      pin_role   <= 1'b0;
    end else if (pend_wr) begin
      unique case (pend_sel)
        `FSCR_SEL_ONE: begin
          // RULE_05 range bits writable
          range      <= pend_data[`FSCR_W1_RANGE_LO+2:`FSCR_W1_RANGE_LO];
          tb         <= pend_data[`FSCR_W1_TB];
          sec        <= pend_data[`FSCR_W1_SEC];
          guard_mode <= pend_data[`FSCR_W1_GUARD];
        end
        `FSCR_SEL_TWO: begin
          lockdown  <= pend_data[`FSCR_W2_LOCKDOWN];
          // RULE_17 four-lane mode holds enable
          qe        <= pend_data[`FSCR_W2_QE] | (qe & quad_mode);
          // RULE_14 one-time locks only set
          otp_locks <= otp_locks | pend_data[`FSCR_W2_OTP_LO+2:`FSCR_W2_OTP_LO];
          invert    <= pend_data[`FSCR_W2_INVERT];
        end
        `FSCR_SEL_THREE: begin
          guard_scheme_select      <= pend_data[`FSCR_W3_WPS];
          drv      <= pend_data[`FSCR_W3_DRV_LO+1:`FSCR_W3_DRV_LO];
          pin_role <= pend_data[`FSCR_W3_ROLE];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Four-lane command mode and individual block locks
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      quad_mode <= 1'b0;
    end else if (cmd_ok && i_cmd.kind == FSCR_ENTER_QUAD) begin
      // RULE_16 entry needs four-lane enable
      if (qe) begin
        quad_mode <= 1'b1;
      end
    end else if (cmd_ok && (i_cmd.kind == FSCR_EXIT_QUAD || i_cmd.kind == FSCR_SOFT_RESET)) begin
      quad_mode <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    // RULE_19 all locks set at power-on and soft reset
    if (!i_nrst || (cmd_ok && i_cmd.kind == FSCR_SOFT_RESET)) begin
      o_block_locks <= '1;
    end else if (cmd_ok && int'(i_cmd.index) < BLOCK_LOCKS) begin
      if (i_cmd.kind == FSCR_BLOCK_LOCK) begin
        o_block_locks[i_cmd.index] <= 1'b1;
      end else if (i_cmd.kind == FSCR_BLOCK_UNLOCK) begin
        o_block_locks[i_cmd.index] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status read port, acknowledge and decoded configuration outputs
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rd_valid  <= 1'b0;
      o_rd_data   <= 8'h00;
      o_cmd_taken <= 1'b0;
    end else begin
      o_rd_valid  <= cmd_ok && i_cmd.kind == FSCR_READ_SR;
      // RULE_16 refused entry is not taken
      o_cmd_taken <= cmd_ok && (!is_kind_wr || sr_wr_ok) &&
                     !(i_cmd.kind == FSCR_ENTER_QUAD && !qe);
      if (cmd_ok && i_cmd.kind == FSCR_READ_SR) begin
        o_rd_data <= status_word(i_cmd.sel);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cfg <= '0;
    end else begin
      o_cfg.busy         <= busy;
      o_cfg.write_enable_latch          <= write_enable_latch;
      o_cfg.paused       <= paused;
      o_cfg.quad_mode    <= quad_mode;
      o_cfg.range        <= range;
      // RULE_06 direction select
      o_cfg.from_bottom  <= tb;
      // RULE_07 sector or block units
      o_cfg.sectors      <= sec;
      // RULE_08 invert the region
      o_cfg.invert       <= invert;
      // RULE_18 protection scheme choice
      o_cfg.area_scheme  <= !guard_scheme_select;
      o_cfg.lock_scheme  <= guard_scheme_select;
      o_cfg.otp_locks    <= otp_locks;
      o_cfg.drive_pct    <= drive_pct(drv);
      // RULE_15 pins become data lanes
      o_cfg.lanes23_data <= qe;
      o_cfg.guard_pin_en <= !qe;
      // RULE_21 shared pin role
      o_cfg.pause_en     <= !qe && !pin_role;
      o_cfg.reset_en     <= !qe && pin_role;
    end
  end

endmodule : fscr_top

// ==== tb/fscr_top_asserts.sv ====
// Concurrent checks on the ports of the status register bank.
`timescale 1ns/1ps
module fscr_top_asserts
  import fscr_pkg::*;
#(
  parameter int SR_WRITE_CYC = 8,
  parameter int BLOCK_LOCKS  = 62
) (
  input wire logic                   i_ref_clk,
  input wire logic                   i_nrst,
  input wire fscr_cmd_t              i_cmd,
  input wire logic                   i_op_done,
  input wire logic                   i_write_guard_pin,
  input wire logic                   o_rd_valid,
  input wire logic [7:0]             o_rd_data,
  input wire logic                   o_cmd_taken,
  input wire fscr_cfg_t              o_cfg,
  input wire logic [BLOCK_LOCKS-1:0] o_block_locks
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  chk_read_answer:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_READ_SR && i_cmd.sel != 2'h3 |=> o_rd_valid)
    else $error("status read not answered");
  chk_busy_filter:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_WRITE_ENABLE |=> o_cmd_taken == !o_cfg.busy)
    else $error("write enable taken against busy state");
  chk_wel_set:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_WRITE_ENABLE ##1 o_cmd_taken |=> o_cfg.write_enable_latch)
    else $error("latch not set after write enable");
  chk_wdis_clear:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_WRITE_DISABLE ##1 o_cmd_taken |=> !o_cfg.write_enable_latch)
    else $error("latch not cleared after write disable");
  chk_srw_busy:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_WRITE_SR ##1 o_cmd_taken
                     |=> (o_cfg.busy && !o_cfg.write_enable_latch) [*2])
    else $error("status write not shown busy");
  chk_quad_gate:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_ENTER_QUAD ##1 !o_cfg.lanes23_data
                     |-> !o_cmd_taken)
    else $error("quad entry taken without lane enable");
  chk_suspend_flag:
    assert property (i_cmd.valid && i_cmd.kind == FSCR_SUSPEND ##1 o_cmd_taken
                     |=> o_cfg.paused && !o_cfg.busy)
    else $error("suspend did not set paused flag");
  chk_locks_reset:
    assert property ($rose(i_nrst) |-> &o_block_locks)
    else $error("block locks not all set after reset");
  chk_lane_roles:
    assert property (o_cfg.lanes23_data |-> !(o_cfg.guard_pin_en || o_cfg.pause_en || o_cfg.reset_en))
    else $error("pin roles active with lanes enabled");
  chk_otp_sticky:
    assert property (($past(o_cfg.otp_locks) & ~o_cfg.otp_locks) == 3'h0)
    else $error("area lock cleared");
  chk_drive_map:
    assert property (o_cfg.drive_pct != 7'h00 |-> o_cfg.drive_pct inside {7'h64, 7'h4B, 7'h32, 7'h19})
    else $error("drive strength out of range");
  chk_scheme_pick:
    assert property (o_cfg.drive_pct != 7'h00 |-> o_cfg.area_scheme != o_cfg.lock_scheme)
    else $error("protection schemes not exclusive");
endmodule : fscr_top_asserts

bind fscr_top fscr_top_asserts #(
  .SR_WRITE_CYC(SR_WRITE_CYC),
  .BLOCK_LOCKS (BLOCK_LOCKS)
) u_chk (
  .i_ref_clk        (i_ref_clk),
  .i_nrst           (i_nrst),
  .i_cmd            (i_cmd),
  .i_op_done        (i_op_done),
  .i_write_guard_pin(i_write_guard_pin),
  .o_rd_valid       (o_rd_valid),
  .o_rd_data        (o_rd_data),
  .o_cmd_taken      (o_cmd_taken),
  .o_cfg            (o_cfg),
  .o_block_locks    (o_block_locks)
);

// ==== tb/fscr_host_model.sv ====
// Host model that issues decoded instructions and array completion pulses.
`timescale 1ns/1ps
module fscr_host_model
  import fscr_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_cmd_taken,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output fscr_cmd_t       o_cmd,
  output logic            o_op_done
);
  initial begin
    o_cmd     = '0;
    o_op_done = 1'b0;
  end

  // One instruction for one cycle, then the answer just after the edge that takes it.
  task automatic xfer(input fscr_kind_t k, input logic [1:0] s, input logic [7:0] d,
                      output logic tk, output logic [7:0] rd);
    @(posedge i_ref_clk);
    o_cmd <= '{valid: 1'b1, kind: k, sel: s, data: d, index: 6'h00};
    @(posedge i_ref_clk);
    o_cmd.valid <= 1'b0;
    o_cmd.sel   <= ~s;
    o_cmd.data  <= ~d;
    #1;
    tk = i_cmd_taken;
    rd = i_rd_valid ? i_rd_data : 8'hXX;
  endtask : xfer

  task automatic done_pulse;
    @(posedge i_ref_clk);
    o_op_done <= 1'b1;
    @(posedge i_ref_clk);
    o_op_done <= 1'b0;
  endtask : done_pulse
endmodule : fscr_host_model

// ==== tb/tb_top.sv ====
// Self-checking testbench of the status register bank.
`timescale 1ns/1ps
module tb_top;
  import fscr_pkg::*;
  localparam int CYC = 12;
  logic        i_ref_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_write_guard_pin = 1'b1;
  fscr_cmd_t   i_cmd;
  logic        i_op_done;
  logic        o_rd_valid;
  logic        o_cmd_taken;
  logic [7:0]  o_rd_data;
  fscr_cfg_t   o_cfg;
  logic [61:0] o_block_locks;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'h07C87D29;
  logic        tk;
  logic [7:0]  rd;
  logic [7:0]  v;
  logic [7:0]  otp;

  always #50 i_ref_clk = ~i_ref_clk;

  fscr_top #(.SR_WRITE_CYC(CYC), .BLOCK_LOCKS(62)) dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cmd(i_cmd), .i_op_done(i_op_done),
    .i_write_guard_pin(i_write_guard_pin), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_cmd_taken(o_cmd_taken), .o_cfg(o_cfg), .o_block_locks(o_block_locks));

  fscr_host_model host (
    .i_ref_clk(i_ref_clk), .i_cmd_taken(o_cmd_taken), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_cmd(i_cmd), .o_op_done(i_op_done));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] pct(input logic [1:0] code);
    return 8'h64 - 8'h19 * {6'h00, code};
  endfunction : pct

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdw(input logic [1:0] s);
    logic t;
    host.xfer(FSCR_READ_SR, s, 8'h00, t, rd);
  endtask : rdw

  task automatic wait_idle;
    for (int n = 0; n < 40; n++) begin
      rdw(2'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic wsr(input logic [1:0] s, input logic [7:0] d);
    logic t;
    host.xfer(FSCR_WRITE_ENABLE, 2'h0, 8'h00, t, rd);
    host.xfer(FSCR_WRITE_SR, s, d, tk, rd);
    if (tk === 1'b1) wait_idle();
  endtask : wsr

  task automatic pin(input logic lvl);
    @(posedge i_ref_clk);
    i_write_guard_pin <= lvl;
  endtask : pin

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(100 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk({7'h00, &o_block_locks}, 8'h01);
    rdw(2'h0);
    chk(rd, 8'h00);
    rdw(2'h2);
    chk(rd, 8'h60);
    host.xfer(FSCR_WRITE_SR, 2'h0, 8'h1C, tk, rd);
    chk({7'h00, tk}, 8'h00);
    for (int n = 0; n < 6; n++) begin
      seed = xs(seed);
      // guard mode and status-only bits written as zero.
      v = (n == 0) ? 8'h7C : seed[7:0] & 8'h7C;
      host.xfer(FSCR_WRITE_ENABLE, 2'h0, 8'h00, tk, rd);
      host.xfer(FSCR_WRITE_SR, 2'h0, v, tk, rd);
      rdw(2'h0);
      chk(rd & 8'h03, 8'h01);
      host.xfer(FSCR_WRITE_ENABLE, 2'h0, 8'h00, tk, rd);
      chk({7'h00, tk}, 8'h00);
      wait_idle();
      chk(rd, v);
      chk({5'h00, o_cfg.range}, {5'h00, v[4:2]});
      chk({6'h00, o_cfg.from_bottom, o_cfg.sectors}, {6'h00, v[5], v[6]});
    end
    for (int n = 0; n < 4; n++) begin
      seed = xs(seed);
      v = {seed[7], n[1:0], 2'h0, seed[2], 2'h0};
      wsr(2'h2, v);
      rdw(2'h2);
      chk(rd, v);
      chk({1'b0, o_cfg.drive_pct}, pct(n[1:0]));
      chk({7'h00, o_cfg.lock_scheme}, {7'h00, v[2]});
      chk({6'h00, o_cfg.reset_en, o_cfg.pause_en}, {6'h00, v[7], !v[7]});
    end
    otp = 8'h00;
    for (int n = 0; n < 4; n++) begin
      seed = xs(seed);
      v = (n == 3) ? 8'h00 : seed[7:0] & 8'h78;
      wsr(2'h1, v);
      otp = otp | (v & 8'h38);
      rdw(2'h1);
      chk(rd, (v & 8'h40) | otp);
    end
    wsr(2'h0, 8'h80);
    pin(1'b0);
    wsr(2'h0, 8'h84);
    chk({7'h00, tk}, 8'h00);
    pin(1'b1);
    wsr(2'h1, 8'h02);
    chk({7'h00, o_cfg.lanes23_data}, 8'h01);
    pin(1'b0);
    wsr(2'h0, 8'h84);
    chk({7'h00, tk}, 8'h01);
    host.xfer(FSCR_ENTER_QUAD, 2'h0, 8'h00, tk, rd);
    wsr(2'h1, 8'h00);
    rdw(2'h1);
    chk(rd & 8'h02, 8'h02);
    host.xfer(FSCR_EXIT_QUAD, 2'h0, 8'h00, tk, rd);
    pin(1'b1);
    wsr(2'h1, 8'h00);
    host.xfer(FSCR_ENTER_QUAD, 2'h0, 8'h00, tk, rd);
    chk({7'h00, tk, o_cfg.quad_mode}, 8'h00);
    host.xfer(FSCR_WRITE_ENABLE, 2'h0, 8'h00, tk, rd);
    host.xfer(FSCR_PROGRAM, 2'h0, 8'h00, tk, rd);
    host.xfer(FSCR_SUSPEND, 2'h0, 8'h00, tk, rd);
    rdw(2'h1);
    chk(rd & 8'h80, 8'h80);
    host.xfer(FSCR_RESUME, 2'h0, 8'h00, tk, rd);
    rdw(2'h1);
    chk(rd & 8'h80, 8'h00);
    host.done_pulse();
    rdw(2'h0);
    chk(rd & 8'h03, 8'h00);
    host.xfer(FSCR_WRITE_ENABLE, 2'h0, 8'h00, tk, rd);
    rdw(2'h0);
    chk(rd & 8'h03, 8'h02);
    host.xfer(FSCR_WRITE_DISABLE, 2'h0, 8'h00, tk, rd);
    rdw(2'h0);
    chk(rd & 8'h03, 8'h00);
    host.xfer(FSCR_BLOCK_UNLOCK, 2'h0, 8'h00, tk, rd);
    chk({7'h00, o_block_locks[0]}, 8'h00);
    host.xfer(FSCR_SOFT_RESET, 2'h0, 8'h00, tk, rd);
    chk({7'h00, &o_block_locks}, 8'h01);
    wsr(2'h1, 8'h01);
    wsr(2'h0, 8'h00);
    chk({7'h00, tk}, 8'h00);
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rdw(2'h1);
    chk(rd & 8'h81, 8'h00);
    complete_run();
  end
endmodule : tb_top
